// ==== regop_shift_skip_exec.sv ====
// What this block does
// [RULE_01] Code 10000 sets ones, 01000 clears
// [RULE_02] Copy codes pass A, M, Q, Q|M
// [RULE_03] Complement codes write inverted A, M, Q, Q|M
// [RULE_04] Sum codes add A to M, Q, Q|M
// [RULE_05] Xor codes combine A with M, Q, Q|M
// [RULE_06] And codes combine A with M, Q, Q|M
// [RULE_07] Nand codes invert A and M, Q, Q|M
// [RULE_08] Copy results ignore instruction bit 7
// [RULE_09] Shifts move A, Q or QA by count
// [RULE_10] Right shifts sign extend, left shifts rotate
// [RULE_11] Counts up to 1F, long shifts too
// [RULE_12] Bits 7..5 select shift register and direction
// [RULE_13] Skip decoded from mode zero, submode one
// [RULE_14] Skip taken adds count plus one
// [RULE_15] Codes 0-3 test A zero and sign
// [RULE_16] Codes 4-7 test Q zero and sign
// [RULE_17] Codes 8, 9 test selective skip switch
// [RULE_18] Codes A, B test, then clear overflow
// [RULE_19] Codes C, D test, then clear parity
// [RULE_20] Codes E, F test, then clear protect fault
// [RULE_21] Protect fault set only while protection enabled
// [RULE_22] One's complement subtractive adder keeps negative zero
// [RULE_23] Field decode: select bits, operands, destinations
// [RULE_24] Select bits pick sum, xor, and, nand
// [RULE_25] Overflow skips test before clearing
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module regop_shift_skip_exec
   import regop_pkg::*;
(
   // Clock, enable and reset
   input wire logic ref_clk_i,
   input wire logic ce_i,
   input wire logic rst_i,
   // Sequencer request and answer
   input wire exec_req_s req_i,
   output var exec_rsp_s rsp_o,
   input wire logic m_load_i,
   input wire logic [WORD_W-1:0] m_data_i,
   // Protection and parity events
   input wire prot_evt_s prot_i,
   input wire logic parity_err_i,
   // Operator switches
   input wire logic skip_sw_i,
   input wire logic protect_sw_i,
   // Register and indicator outputs
   output var logic [WORD_W-1:0] a_o,
   output var logic [WORD_W-1:0] q_o,
   output var logic [WORD_W-1:0] m_o,
   output var logic overflow_o,
   output var logic parity_fault_o,
   output var logic protect_fault_o,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [WB_ADR_W-1:0] wb_adr_i,
   input wire logic [WB_DAT_W-1:0] wb_dat_i,
   output var logic [WB_DAT_W-1:0] wb_dat_o,
   output var logic wb_ack_o
);

   state_s s_r;
   state_s s_nxt;

   // One's complement add through a subtractor
   function automatic logic [WORD_W:0] oc_add(
      input logic [WORD_W-1:0] x,
      input logic [WORD_W-1:0] y);
      logic [WORD_W:0] d;
      logic [WORD_W-1:0] r;
      d = {1'b0, x} - {1'b0, ~y};
      r = d[WORD_W] ? d[WORD_W-1:0] - ONE_W : d[WORD_W-1:0];
      oc_add = {(x[WORD_W-1] == y[WORD_W-1]) && (r[WORD_W-1] != x[WORD_W-1]), r};
   endfunction : oc_add

   function automatic logic [WORD_W-1:0] sra16(
      input logic [WORD_W-1:0] x,
      input logic [4:0] n);
      sra16 = WORD_W'($signed(x) >>> n);
   endfunction : sra16

   function automatic logic [WORD_W-1:0] rotl16(
      input logic [WORD_W-1:0] x,
      input logic [4:0] n);
      logic [LONG_W-1:0] t;
      t = {x, x} << n[3:0];
      rotl16 = t[LONG_W-1:WORD_W];
   endfunction : rotl16

   function automatic logic [LONG_W-1:0] rotl32(
      input logic [LONG_W-1:0] x,
      input logic [4:0] n);
      logic [2*LONG_W-1:0] t;
      t = {x, x} << n;
      rotl32 = t[2*LONG_W-1:LONG_W];
   endfunction : rotl32

   // Skip condition test
   function automatic logic skip_test(
      input skip_condition_code_e c,
      input logic [WORD_W-1:0] a,
      input logic [WORD_W-1:0] q,
      input logic sw,
      input logic ovf,
      input logic par,
      input logic prot);
      case (c)
         skip_acc_zero: skip_test = (a == ZERO); // [RULE_15]
         skip_acc_nonzero: skip_test = (a != ZERO);
         skip_acc_pos: skip_test = !a[WORD_W-1];
         skip_acc_neg: skip_test = a[WORD_W-1];
         skip_qreg_zero: skip_test = (q == ZERO); // [RULE_16]
         skip_qreg_nonzero: skip_test = (q != ZERO);
         skip_qreg_pos: skip_test = !q[WORD_W-1];
         skip_qreg_neg: skip_test = q[WORD_W-1];
         skip_switch_on: skip_test = sw; // [RULE_17]
         skip_switch_off: skip_test = !sw;
         skip_on_overflow: skip_test = ovf; // [RULE_18]
         skip_no_overflow: skip_test = !ovf;
         skip_parity_err: skip_test = par; // [RULE_19]
         skip_no_parity_err: skip_test = !par;
         skip_protect_fault: skip_test = prot; // [RULE_20]
         skip_no_protect_fault: skip_test = !prot;
         default: skip_test = 1'b0;
      endcase
   endfunction : skip_test

   // Byte lane merge for register writes
   function automatic logic [WORD_W-1:0] merge16(
      input logic [WORD_W-1:0] old,
      input logic [WB_DAT_W-1:0] d,
      input logic [3:0] sel);
      merge16 = old;
      if (sel[0]) begin
         merge16[7:0] = d[7:0];
      end
      if (sel[1]) begin
         merge16[15:8] = d[15:8];
      end
   endfunction : merge16

   // Instruction decode
   logic [3:0] opc;
   logic basic;
   logic is_inter;
   logic is_shift;
   logic is_skip;
   logic and_select;
   logic xor_select;
   op2_sel_e op2_sel;
   logic [WORD_W-1:0] op1;
   logic [WORD_W-1:0] op2;
   logic [WORD_W:0] sum;
   logic [WORD_W-1:0] ir_res;
   logic [4:0] sh_cnt;
   logic [LONG_W-1:0] qa;
   logic [LONG_W-1:0] qa_res;
   skip_condition_code_e skip_condition_code;
   logic [WORD_W-1:0] skip_cnt;
   logic hit;
   logic [WB_DAT_W-1:0] rd_data;

   assign opc = req_i.instr[OPC_MSB:OPC_LSB];
   assign basic = req_i.valid && (req_i.instr[MODE_MSB:MODE_LSB] == MODE_BASIC);
   assign is_inter = basic && (opc == OPC_INTER);
   assign is_shift = basic && (opc == OPC_SHIFT);
   assign is_skip = basic && (opc == OPC_SKIP); // [RULE_13]
   assign and_select = req_i.instr[AND_SEL_BIT]; // [RULE_23]
   assign xor_select = req_i.instr[XOR_SEL_BIT];
   assign op2_sel = op2_sel_e'(req_i.instr[OP2_MSB:OP2_LSB]);
   assign op1 = req_i.instr[OP1_SEL_BIT] ? s_r.a : ONES; // [RULE_23]

   always_comb begin
      case (op2_sel)
         OP2_ONES: op2 = ONES;
         OP2_MEM: op2 = s_r.m;
         OP2_QREG: op2 = s_r.q;
         OP2_QM_OR: op2 = s_r.q | s_r.m; // [RULE_02]
         default: op2 = ONES;
      endcase
   end

   assign sum = oc_add(op1, op2); // [RULE_22]

   // A copy is a sum or an and with ones, so bit 7 does not matter
   always_comb begin // [RULE_08]
      case ({and_select, xor_select})
         2'b00: ir_res = sum[WORD_W-1:0]; // [RULE_04] [RULE_24]
         2'b01: ir_res = op1 ^ op2; // [RULE_05] [RULE_03] [RULE_01]
         2'b10: ir_res = op1 & op2; // [RULE_06] [RULE_02] [RULE_01]
         2'b11: ir_res = ~(op1 & op2); // [RULE_07] [RULE_03]
         default: ir_res = ZERO;
      endcase
   end

   assign sh_cnt = req_i.instr[SH_CNT_MSB:0]; // [RULE_09] [RULE_11]
   assign qa = {s_r.q, s_r.a};
   assign qa_res = req_i.instr[SH_LEFT_BIT] ? rotl32(qa, sh_cnt) : LONG_W'($signed(qa) >>> sh_cnt);
   assign skip_condition_code = skip_condition_code_e'(req_i.instr[SKC_MSB:SKC_LSB]);
   assign skip_cnt = {12'h000, req_i.instr[SKN_MSB:0]};
   // Indicators are sampled before this cycle clears them
   assign hit = skip_test(skip_condition_code, s_r.a, s_r.q, s_r.skip_sw, s_r.ovf, s_r.par, s_r.prot); // [RULE_25]

   always_comb begin
      rd_data = '0;
      case (wb_adr_i)
         ADDR_A: rd_data = {WB_PAD, s_r.a};
         ADDR_Q: rd_data = {WB_PAD, s_r.q};
         ADDR_M: rd_data = {WB_PAD, s_r.m};
         ADDR_STAT: begin
            rd_data[STAT_OVF_BIT] = s_r.ovf;
            rd_data[STAT_PAR_BIT] = s_r.par;
            rd_data[STAT_PROT_BIT] = s_r.prot;
            rd_data[STAT_PEN_BIT] = s_r.prot_en;
            rd_data[STAT_SSW_BIT] = s_r.skip_sw;
         end
         default: rd_data = '0;
      endcase
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.rsp.done = 1'b0;
      s_nxt.wb_ack = 1'b0;
      // Switch synchronisers, change accepted when last two agree
      s_nxt.ssw_sync = {s_r.ssw_sync[1:0], skip_sw_i};
      s_nxt.pen_sync = {s_r.pen_sync[1:0], protect_sw_i};
      if (s_r.ssw_sync[2] == s_r.ssw_sync[1]) begin
         s_nxt.skip_sw = s_r.ssw_sync[2];
      end
      if (s_r.pen_sync[2] == s_r.pen_sync[1]) begin
         s_nxt.prot_en = s_r.pen_sync[2];
      end
      // Register bus: one ack per request, write one to clear flags
      if (wb_cyc_i && wb_stb_i && !s_r.wb_ack) begin
         s_nxt.wb_ack = 1'b1;
         s_nxt.wb_dat = rd_data;
         if (wb_we_i) begin
            case (wb_adr_i)
               ADDR_A: s_nxt.a = merge16(s_r.a, wb_dat_i, wb_sel_i);
               ADDR_Q: s_nxt.q = merge16(s_r.q, wb_dat_i, wb_sel_i);
               ADDR_M: s_nxt.m = merge16(s_r.m, wb_dat_i, wb_sel_i);
               ADDR_STAT: begin
                  if (wb_sel_i[0] && wb_dat_i[STAT_OVF_BIT]) begin
                     s_nxt.ovf = 1'b0;
                  end
                  if (wb_sel_i[0] && wb_dat_i[STAT_PAR_BIT]) begin
                     s_nxt.par = 1'b0;
                  end
                  if (wb_sel_i[0] && wb_dat_i[STAT_PROT_BIT]) begin
                     s_nxt.prot = 1'b0;
                  end
               end
               default: ;
            endcase
         end
      end
      if (m_load_i) begin
         s_nxt.m = m_data_i;
      end
      // Execution overrides bus writes to the same register
      if (req_i.valid) begin
         s_nxt.rsp.done = 1'b1;
         s_nxt.rsp.next_addr = req_i.p_addr + ONE_W;
      end
      if (is_inter) begin
         if (req_i.instr[DEST_A_BIT]) begin
            s_nxt.a = ir_res; // [RULE_23]
         end
         if (req_i.instr[DEST_Q_BIT]) begin
            s_nxt.q = ir_res;
         end
         if (req_i.instr[DEST_M_BIT]) begin
            s_nxt.m = ir_res;
         end
      end
      if (is_shift) begin
         case ({req_i.instr[SH_A_BIT], req_i.instr[SH_Q_BIT]}) // [RULE_12]
            2'b10: s_nxt.a = req_i.instr[SH_LEFT_BIT] ? rotl16(s_r.a, sh_cnt) : sra16(s_r.a, sh_cnt); // [RULE_10]
            2'b01: s_nxt.q = req_i.instr[SH_LEFT_BIT] ? rotl16(s_r.q, sh_cnt) : sra16(s_r.q, sh_cnt);
            2'b11: begin
               s_nxt.q = qa_res[LONG_W-1:WORD_W]; // [RULE_10] [RULE_11]
               s_nxt.a = qa_res[WORD_W-1:0];
            end
            default: ;
         endcase
      end
      if (is_skip) begin
         if (hit) begin
            s_nxt.rsp.next_addr = req_i.p_addr + skip_cnt + ONE_W; // [RULE_14]
         end
         case (skip_condition_code)
            skip_on_overflow, skip_no_overflow: s_nxt.ovf = 1'b0; // [RULE_18] [RULE_25]
            skip_parity_err, skip_no_parity_err: s_nxt.par = 1'b0; // [RULE_19]
            skip_protect_fault, skip_no_protect_fault: s_nxt.prot = 1'b0; // [RULE_20]
            default: ;
         endcase
      end
      // Sets come last so they win over any clear
      if (is_inter && !and_select && !xor_select && sum[WORD_W]) begin
         s_nxt.ovf = 1'b1; // [RULE_24]
      end
      if (parity_err_i) begin
         s_nxt.par = 1'b1;
      end
      if (prot_i.step) begin
         s_nxt.last_unprot = !prot_i.prot_instr;
         if (s_r.prot_en && !prot_i.prot_instr && (prot_i.prot_write || prot_i.mask_change)) begin
            s_nxt.prot = 1'b1; // [RULE_21]
         end
         if (s_r.prot_en && prot_i.prot_instr && s_r.last_unprot && !prot_i.int_entry) begin
            s_nxt.prot = 1'b1; // [RULE_21]
         end
      end
      if (!ce_i) begin
         s_nxt = s_r;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rsp_o = s_r.rsp;
   assign a_o = s_r.a;
   assign q_o = s_r.q;
   assign m_o = s_r.m;
   assign overflow_o = s_r.ovf;
   assign parity_fault_o = s_r.par;
   assign protect_fault_o = s_r.prot;
   assign wb_dat_o = s_r.wb_dat;
   assign wb_ack_o = s_r.wb_ack;

   // Checks
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   logic [IR_MSB-IR_LSB:0] ir_code;
   assign ir_code = req_i.instr[IR_MSB:IR_LSB];

   set_ones_a: assert property (ce_i && is_inter && ir_code == IR_SET && req_i.instr[DEST_A_BIT]
      |=> a_o == ONES) else $error("set ones failed"); // [RULE_01]
   clear_zero_a: assert property (ce_i && is_inter && ir_code == IR_CLR && req_i.instr[DEST_Q_BIT]
      |=> q_o == ZERO) else $error("clear failed"); // [RULE_01]
   copy_inv_a: assert property (ce_i && is_inter && ir_code == IR_TCA && req_i.instr[DEST_A_BIT]
      |=> a_o == ~$past(a_o)) else $error("complement copy failed"); // [RULE_03]
   xor_op_a: assert property (ce_i && is_inter && !and_select && xor_select && op1 == a_o
      && op2_sel == OP2_QREG && req_i.instr[DEST_A_BIT]
      |=> a_o == ($past(a_o) ^ $past(q_o))) else $error("xor failed"); // [RULE_05]
   neg_zero_a: assert property (ce_i && is_inter && ir_code == 5'h05 && a_o == ONES && m_o == ONES
      && req_i.instr[DEST_A_BIT] |=> a_o == ONES) else $error("negative zero lost"); // [RULE_22]
   shift_right_a: assert property (ce_i && is_shift && req_i.instr[IR_MSB:OP1_SEL_BIT] == SH_A_RIGHT
      |=> $signed(a_o) == ($signed($past(a_o)) >>> $past(sh_cnt))) else $error("shift failed"); // [RULE_10]
   skip_addr_a: assert property (ce_i && is_skip
      |=> rsp_o.done && rsp_o.next_addr == $past(req_i.p_addr) + ONE_W
      + ($past(hit) ? $past(skip_cnt) : ZERO)) else $error("skip address wrong"); // [RULE_14]
   ovf_skip_a: assert property (ce_i && is_skip && skip_condition_code == skip_on_overflow
      |=> !overflow_o && (rsp_o.next_addr != $past(req_i.p_addr) + ONE_W
      || !$past(overflow_o) || $past(skip_cnt) == ZERO)) else $error("overflow skip wrong"); // [RULE_25]
   parity_clr_a: assert property (ce_i && is_skip && skip_condition_code == skip_parity_err
      && !parity_err_i |=> !parity_fault_o) else $error("parity not cleared"); // [RULE_19]
   prot_never_a: assert property ($rose(protect_fault_o) |-> $past(s_r.prot_en))
      else $error("protect fault while disabled"); // [RULE_21]

   skip_taken_c: cover property (ce_i && is_skip && hit && skip_cnt != ZERO);
   long_left_c: cover property (ce_i && is_shift && req_i.instr[IR_MSB:OP1_SEL_BIT] == SH_QA_LEFT);
   sum_ovf_c: cover property (ce_i && is_inter && !and_select && !xor_select && sum[WORD_W]);
   wb_write_c: cover property (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o);
endmodule : regop_shift_skip_exec
`default_nettype wire

// ==== regop_pkg.sv ====
package regop_pkg;
   localparam int WORD_W = 16;
   localparam int LONG_W = 32;
   localparam int WB_ADR_W = 8;
   localparam int WB_DAT_W = 32;
   localparam logic [WORD_W-1:0] ONES = 16'hFFFF;
   localparam logic [WORD_W-1:0] ZERO = 16'h0000;
   localparam logic [WORD_W-1:0] ONE_W = 16'h0001;
   localparam logic [WORD_W-1:0] WB_PAD = 16'h0000;
   // Instruction fields
   localparam int MODE_MSB = 15;
   localparam int MODE_LSB = 12;
   localparam int OPC_MSB = 11;
   localparam int OPC_LSB = 8;
   localparam int AND_SEL_BIT = 7;
   localparam int XOR_SEL_BIT = 6;
   localparam int OP1_SEL_BIT = 5;
   localparam int OP2_MSB = 4;
   localparam int OP2_LSB = 3;
   localparam int DEST_A_BIT = 2;
   localparam int DEST_Q_BIT = 1;
   localparam int DEST_M_BIT = 0;
   localparam int SH_LEFT_BIT = 7;
   localparam int SH_A_BIT = 6;
   localparam int SH_Q_BIT = 5;
   localparam int SH_CNT_MSB = 4;
   localparam int SKC_MSB = 7;
   localparam int SKC_LSB = 4;
   localparam int SKN_MSB = 3;
   localparam int IR_MSB = 7;
   localparam int IR_LSB = 3;
   localparam logic [3:0] MODE_BASIC = 4'h0;
   localparam logic [3:0] OPC_SKIP = 4'h1;
   localparam logic [3:0] OPC_INTER = 4'h8;
   localparam logic [3:0] OPC_SHIFT = 4'hF;
   localparam logic [4:0] IR_SET = 5'h10;
   localparam logic [4:0] IR_CLR = 5'h08;
   localparam logic [4:0] IR_TCA = 5'h0C;
   localparam logic [2:0] SH_A_RIGHT = 3'h2;
   localparam logic [2:0] SH_QA_LEFT = 3'h7;
   // Register map
   localparam logic [WB_ADR_W-1:0] ADDR_A = 8'h00;
   localparam logic [WB_ADR_W-1:0] ADDR_Q = 8'h04;
   localparam logic [WB_ADR_W-1:0] ADDR_M = 8'h08;
   localparam logic [WB_ADR_W-1:0] ADDR_STAT = 8'h0C;
   localparam int STAT_OVF_BIT = 0;
   localparam int STAT_PAR_BIT = 1;
   localparam int STAT_PROT_BIT = 2;
   localparam int STAT_PEN_BIT = 3;
   localparam int STAT_SSW_BIT = 4;

   typedef enum logic [1:0] {
      OP2_ONES = 2'b00, OP2_MEM = 2'b01,
      OP2_QREG = 2'b10, OP2_QM_OR = 2'b11
   } op2_sel_e;

   typedef enum logic [3:0] {
      skip_acc_zero = 4'h0, skip_acc_nonzero = 4'h1,
      skip_acc_pos = 4'h2, skip_acc_neg = 4'h3,
      skip_qreg_zero = 4'h4, skip_qreg_nonzero = 4'h5,
      skip_qreg_pos = 4'h6, skip_qreg_neg = 4'h7,
      skip_switch_on = 4'h8, skip_switch_off = 4'h9,
      skip_on_overflow = 4'hA, skip_no_overflow = 4'hB,
      skip_parity_err = 4'hC, skip_no_parity_err = 4'hD,
      skip_protect_fault = 4'hE, skip_no_protect_fault = 4'hF
   } skip_condition_code_e;

   typedef struct packed {
      logic valid;
      logic [WORD_W-1:0] instr;
      logic [WORD_W-1:0] p_addr;
   } exec_req_s;

   typedef struct packed {
      logic done;
      logic [WORD_W-1:0] next_addr;
   } exec_rsp_s;

   typedef struct packed {
      logic step;
      logic prot_instr;
      logic int_entry;
      logic prot_write;
      logic mask_change;
   } prot_evt_s;

   typedef struct packed {
      logic [WORD_W-1:0] a;
      logic [WORD_W-1:0] q;
      logic [WORD_W-1:0] m;
      logic ovf;
      logic par;
      logic prot;
      logic last_unprot;
      logic [2:0] ssw_sync;
      logic [2:0] pen_sync;
      logic skip_sw;
      logic prot_en;
      exec_rsp_s rsp;
      logic wb_ack;
      logic [WB_DAT_W-1:0] wb_dat;
   } state_s;
endpackage : regop_pkg

// ==== seq_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module seq_model
   import regop_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Bench side
   input wire logic go_i,
   input wire logic [WORD_W-1:0] instr_i,
   input wire logic [WORD_W-1:0] p_i,
   input wire prot_evt_s evt_i,
   // Block side
   output var exec_req_s req_o,
   output var prot_evt_s prot_o
);
   // Fields other than valid and step scramble while no request stands
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         req_o <= '0;
         prot_o <= '0;
      end else if (go_i) begin
         req_o <= {1'b1, instr_i, p_i};
         prot_o <= evt_i;
      end else begin
         req_o <= {1'b0, ~req_o[31:0]};
         prot_o <= {1'b0, ~prot_o[3:0]};
      end
   end
endmodule : seq_model
`default_nettype wire

// ==== tb_regop_shift_skip_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_regop_shift_skip_exec
   import regop_pkg::*;
;
   logic clk = 0, rst = 1, go = 0, ssw = 0, psw = 0, perr = 0;
   logic [15:0] g_ins = 0, g_p = 0, ma = 0, mq = 0, mm = 0, a_o, q_o, m_o;
   prot_evt_s g_ev = '0, prot;
   exec_req_s req;
   exec_rsp_s rsp;
   logic movf = 0, mpar = 0, mprot = 0, msw = 0, mpen = 0, ovf, par, pf, ack;
   logic cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = 0;
   logic [31:0] dat = 0, rdat;
   logic [66:0] xq[$];
   logic [31:0] rq[$];
   integer num_errors = 0, checks = 0, i, j;
   logic [2:0] shs[6] = '{3'h2, 3'h1, 3'h3, 3'h6, 3'h5, 3'h7};
   logic [4:0] cns[5] = '{5'h00, 5'h01, 5'h0F, 5'h10, 5'h1F};

   always #5 clk = ~clk;

   seq_model seq (.ref_clk_i(clk), .rst_i(rst), .go_i(go), .instr_i(g_ins), .p_i(g_p), .evt_i(g_ev),
      .req_o(req), .prot_o(prot));
   regop_shift_skip_exec dut (.ref_clk_i(clk), .ce_i(1'b1), .rst_i(rst), .req_i(req), .rsp_o(rsp),
      .m_load_i(1'b0), .m_data_i(16'h0000), .prot_i(prot), .parity_err_i(perr), .skip_sw_i(ssw),
      .protect_sw_i(psw), .a_o(a_o), .q_o(q_o), .m_o(m_o), .overflow_o(ovf), .parity_fault_o(par),
      .protect_fault_o(pf), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(4'hF),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack));

   task automatic cmp_exec(input logic [66:0] e, input logic [66:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp_exec

   task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp_rd

   always @(posedge clk) begin
      if (rsp.done === 1'b1) cmp_exec(xq.size() ? xq.pop_front() : 'x, {rsp.next_addr, a_o, q_o, m_o, ovf, par, pf});
      if (ack === 1'b1 && !we) cmp_rd(rq.size() ? rq.pop_front() : 'x, rdat);
   end

   task report_and_stop;
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      cyc <= 0;
      stb <= 0;
      if (n >= 20) begin
         num_errors++;
         report_and_stop();
      end
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      case (a)
         ADDR_A: ma = d[15:0];
         ADDR_Q: mq = d[15:0];
         ADDR_M: mm = d[15:0];
         ADDR_STAT: if (d[2]) mprot = 0;
         default: ;
      endcase
      wb(1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      wb(0, a, 32'h0);
   endtask : rd

   task automatic idle;
      int n;
      @(posedge clk);
      go <= 0;
      n = 0;
      while ((xq.size() || rq.size()) && n < 10) begin
         @(posedge clk);
         n++;
      end
      if (n >= 10) begin
         num_errors++;
         report_and_stop();
      end
   endtask : idle

   task automatic ex(input logic [15:0] ins, input prot_evt_s ev, input logic setf);
      logic [15:0] p, o1, o2, r, nx;
      logic [31:0] w;
      logic [63:0] l;
      logic t;
      logic [7:0] b;
      p = 16'($urandom);
      nx = p + 16'h0001;
      t = 0;
      if (ins[15:8] == 8'h08) begin
         o1 = ins[5] ? ma : ONES;
         case (ins[4:3])
            2'h0: o2 = ONES;
            2'h1: o2 = mm;
            2'h2: o2 = mq;
            default: o2 = mq | mm;
         endcase
         case (ins[7:6])
            2'h0: begin
               {t, r} = {1'b0, o1} - {1'b0, ~o2};
               if (t) r = r - 16'h0001;
               if (o1[15] == o2[15] && r[15] != o1[15]) movf = 1;
            end
            2'h1: r = o1 ^ o2;
            2'h2: r = o1 & o2;
            default: r = ~(o1 & o2);
         endcase
         if (ins[2]) ma = r;
         if (ins[1]) mq = r;
         if (ins[0]) mm = r;
      end else if (ins[15:8] == 8'h0F) begin
         w = {ma, ma} << ins[3:0];
         l = {mq, ma, mq, ma} << ins[4:0];
         case (ins[7:5])
            3'h2: ma = $signed(ma) >>> ins[4:0];
            3'h1: mq = $signed(mq) >>> ins[4:0];
            3'h3: {mq, ma} = $signed({mq, ma}) >>> ins[4:0];
            3'h6: ma = w[31:16];
            3'h5: begin
               w = {mq, mq} << ins[3:0];
               mq = w[31:16];
            end
            3'h7: {mq, ma} = l[63:32];
            default: ;
         endcase
      end else if (ins[15:8] == 8'h01) begin
         b = {ma == 0, !ma[15], mq == 0, !mq[15], msw, movf, mpar, mprot};
         t = b[7 - ins[7:5]] ^ ins[4];
         if (ins[7:5] == 3'h5) movf = 0;
         if (ins[7:5] == 3'h6) mpar = 0;
         if (ins[7:5] == 3'h7) mprot = 0;
         if (t) nx = p + {12'h000, ins[3:0]} + 16'h0001;
      end
      if (setf) mprot = 1;
      xq.push_back({nx, ma, mq, mm, movf, mpar, mprot});
      @(posedge clk);
      go <= 1;
      g_ins <= ins;
      g_p <= p;
      g_ev <= ev;
   endtask : ex

   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end

   initial begin
      void'($urandom(8581));
      repeat (20) @(posedge clk);
      rst <= 0;
      for (i = 0; i < 64; i++) begin
         wr(ADDR_A, $urandom);
         wr(ADDR_Q, $urandom);
         wr(ADDR_M, $urandom);
         ex({8'h08, i[4:0], i[5] ? 3'($urandom) : 3'h6}, '0, 0);
         idle();
      end
      wr(ADDR_A, 32'hFFFF);
      wr(ADDR_M, 32'hFFFF);
      ex(16'h082C, '0, 0);
      idle();
      wr(ADDR_A, 32'h7FFF);
      wr(ADDR_M, 32'h0001);
      ex(16'h0828, '0, 0);
      ex(16'h01A3, '0, 0);
      ex(16'h01B2, '0, 0);
      idle();
      $display("inter-register test done");
      for (i = 0; i < 6; i++) begin
         wr(ADDR_A, $urandom);
         wr(ADDR_Q, $urandom);
         for (j = 0; j < 5; j++) ex({8'h0F, shs[i], cns[j]}, '0, 0);
         idle();
      end
      $display("shift test done");
      for (i = 0; i < 2; i++) begin
         @(posedge clk);
         ssw <= !i[0];
         perr <= 1;
         @(posedge clk);
         perr <= 0;
         msw = !i[0];
         mpar = 1;
         repeat (5) @(posedge clk);
         wr(ADDR_A, i ? $urandom : 32'h0);
         wr(ADDR_Q, i ? $urandom : 32'h8000);
         for (j = 0; j < 16; j++) ex({8'h01, j[3:0], 4'($urandom)}, '0, 0);
         idle();
      end
      $display("skip test done");
      ex(16'h1000, 5'b10000, 0);
      ex(16'h1000, 5'b11000, 0);
      idle();
      @(posedge clk);
      psw <= 1;
      mpen = 1;
      repeat (5) @(posedge clk);
      ex(16'h1000, 5'b10000, 0);
      ex(16'h1000, 5'b11000, 1);
      ex(16'h01E2, '0, 0);
      ex(16'h1000, 5'b10001, 1);
      ex(16'h1000, 5'b10010, 1);
      idle();
      rd(ADDR_STAT, {27'h0, msw, mpen, mprot, mpar, movf});
      wr(ADDR_STAT, 32'h4);
      rd(ADDR_STAT, {27'h0, msw, mpen, mprot, mpar, movf});
      wr(8'h10, 32'h5A5A);
      rd(8'h10, 32'h0);
      rd(ADDR_A, {16'h0, ma});
      idle();
      $display("protect and bus test done");
      report_and_stop();
   end
endmodule : tb_regop_shift_skip_exec
`default_nettype wire
